// >>> src/tnl_device_end.sv
`timescale 1ns/10ps
`default_nettype none

module tnl_device_end #(
    parameter int MS_CYC = tnl_pkg::MS_CYC
) (
    input wire logic CLK, // system clock
    input wire logic RST, // async reset, high
    tnl_link_if.dev LINK, // request link to controller
    input wire logic [5:0] ADDR_SW_ON, // address switches, 1 = ON
    input wire logic TOKEN_PASS, // token received and passed
    input wire logic OTHER_HEARD, // packet from another station
    input wire logic SOLO_CLAIM, // token claimed, no successor
    input wire logic DUP_HEARD, // packet from same address
    input wire logic [15:0] WEIGHT_WORD, // integer weight
    input wire logic [15:0] STATUS_WORD, // scale status
    output logic LED, // green diagnostic led
    output logic [6:0] NODE_ADDR, // node address 1..64
    output tnl_pkg::tnl_net_e NET_STATE // network state
);

    // ----------------------------------------
    // pattern helpers
    // ----------------------------------------
    function automatic logic [2:0] flash_count(input tnl_pkg::tnl_net_e st);
        unique case (st)
            tnl_pkg::NET_IDLE: flash_count = tnl_pkg::IDLE_FLASHES;
            tnl_pkg::NET_SOLO: flash_count = tnl_pkg::SOLO_FLASHES;
            tnl_pkg::NET_DUP: flash_count = tnl_pkg::DUP_FLASHES;
            default: flash_count = tnl_pkg::ONE_FLASH;
        endcase
    endfunction : flash_count

    function automatic logic [15:0] dark_ms(input tnl_pkg::tnl_net_e st);
        unique case (st)
            tnl_pkg::NET_NORMAL: dark_ms = tnl_pkg::SLOT_MS - tnl_pkg::FLASH_ON_MS;
            tnl_pkg::NET_IDLE: dark_ms = tnl_pkg::IDLE_DARK_MS;
            tnl_pkg::NET_SOLO: dark_ms = tnl_pkg::SOLO_DARK_MS;
            tnl_pkg::NET_DUP: dark_ms = tnl_pkg::DUP_DARK_MS;
            default: dark_ms = tnl_pkg::OFFLINE_PERIOD_MS - tnl_pkg::FLASH_ON_MS;
        endcase
    endfunction : dark_ms

    localparam logic [23:0] MS_LAST = 24'(MS_CYC - 1);

    logic [23:0] div_reg;
    logic ms_tick;
    tnl_pkg::tnl_net_e state_reg;
    tnl_pkg::tnl_net_e state_next;
    logic [15:0] timer_reg;
    logic heard_tok_reg;
    logic heard_oth_reg;
    logic [15:0] phase_reg;
    logic [15:0] slot_reg;
    logic led_reg;
    logic [6:0] node_addr_reg;
    logic rsp_valid_reg;
    logic [15:0] rsp_err_reg;
    logic [15:0] rsp_word0_reg;
    logic [15:0] rsp_word1_reg;

    // ----------------------------------------
    // millisecond tick
    // ----------------------------------------
    // divided tick
    assign ms_tick = (div_reg == MS_LAST);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            div_reg <= 24'h000000;
        end else begin
            div_reg <= ms_tick ? 24'h000000 : div_reg + 24'h000001;
        end
    end

    // ----------------------------------------
    // network state
    // ----------------------------------------
    wire state_chg = (state_next != state_reg);
    wire in_offline = (state_reg == tnl_pkg::NET_OFFLINE);
    wire monitor_done = (timer_reg >= tnl_pkg::MONITOR_MS);
    wire token_lost = (timer_reg >= tnl_pkg::TOKEN_LOSS_MS);
    wire dup_quiet = (timer_reg >= tnl_pkg::DUP_QUIET_MS);
    // a fresh duplicate packet restarts the quiet time
    wire timer_clr = state_chg
        | (DUP_HEARD && state_reg == tnl_pkg::NET_DUP)
        | (TOKEN_PASS && state_reg == tnl_pkg::NET_NORMAL);
    wire enter_offline = state_chg && (state_next == tnl_pkg::NET_OFFLINE);

    always_comb begin
        state_next = state_reg;
        if (DUP_HEARD && state_reg != tnl_pkg::NET_DUP) begin
            state_next = tnl_pkg::NET_DUP;
        end else begin
            unique case (state_reg)
                tnl_pkg::NET_OFFLINE: begin
                    // decide only after the full monitor time
                    if (monitor_done) begin
                        if (heard_tok_reg || TOKEN_PASS) begin
                            state_next = tnl_pkg::NET_NORMAL;
                        end else if (heard_oth_reg || OTHER_HEARD) begin
                            state_next = tnl_pkg::NET_IDLE;
                        end else begin
                            state_next = tnl_pkg::NET_SOLO;
                        end
                    end
                end
                tnl_pkg::NET_NORMAL: begin
                    if (SOLO_CLAIM) begin
                        state_next = tnl_pkg::NET_SOLO;
                    end else if (token_lost && !TOKEN_PASS) begin
                        state_next = tnl_pkg::NET_OFFLINE;
                    end
                end
                tnl_pkg::NET_IDLE: begin
                    if (TOKEN_PASS) begin
                        state_next = tnl_pkg::NET_NORMAL;
                    end else if (SOLO_CLAIM) begin
                        state_next = tnl_pkg::NET_SOLO;
                    end
                end
                tnl_pkg::NET_SOLO: begin
                    if (TOKEN_PASS) begin
                        state_next = tnl_pkg::NET_NORMAL;
                    end else if (OTHER_HEARD) begin
                        state_next = tnl_pkg::NET_IDLE;
                    end
                end
                tnl_pkg::NET_DUP: begin
                    // passive until 5 s without the duplicate
                    if (dup_quiet && !DUP_HEARD) begin
                        state_next = tnl_pkg::NET_OFFLINE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg <= tnl_pkg::NET_OFFLINE;
            timer_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            if (timer_clr) begin
                timer_reg <= 16'h0000;
            end else if (ms_tick && timer_reg != tnl_pkg::TIMER_MAX) begin
                timer_reg <= timer_reg + 16'h0001;
            end
        end
    end

    // traffic seen during monitoring; an event on the entry cycle still counts
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            heard_tok_reg <= 1'b0;
            heard_oth_reg <= 1'b0;
        end else begin
            heard_tok_reg <= ((heard_tok_reg && !enter_offline) || TOKEN_PASS)
                && (state_next == tnl_pkg::NET_OFFLINE) && (in_offline || enter_offline);
            heard_oth_reg <= ((heard_oth_reg && !enter_offline) || OTHER_HEARD)
                && (state_next == tnl_pkg::NET_OFFLINE) && (in_offline || enter_offline);
        end
    end

    // ----------------------------------------
    // flash pattern
    // ----------------------------------------
    wire [15:0] lit_span = ({13'h0000, flash_count(state_reg)} - 16'h0001)
        * tnl_pkg::SLOT_MS + tnl_pkg::FLASH_ON_MS;
    wire [15:0] period_last = lit_span + dark_ms(state_reg) - 16'h0001;
    wire phase_wrap = (phase_reg == period_last);
    wire slot_wrap = phase_wrap || (slot_reg == tnl_pkg::SLOT_MS - 16'h0001);
    wire led_next = (phase_reg < lit_span) && (slot_reg < tnl_pkg::FLASH_ON_MS);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            phase_reg <= 16'h0000;
            slot_reg <= 16'h0000;
            led_reg <= 1'b0;
        end else begin
            led_reg <= led_next;
            if (state_chg) begin
                phase_reg <= 16'h0000;
                slot_reg <= 16'h0000;
            end else if (ms_tick) begin
                phase_reg <= phase_wrap ? 16'h0000 : phase_reg + 16'h0001;
                slot_reg <= slot_wrap ? 16'h0000 : slot_reg + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // node address
    // ----------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            node_addr_reg <= 7'h00;
        end else begin
            // OFF switches weigh in, plus one
            node_addr_reg <= {1'b0, ~ADDR_SW_ON} + tnl_pkg::ADDR_OFFSET;
        end
    end

    // ----------------------------------------
    // read request handling
    // ----------------------------------------
    // only a node in token rotation answers
    assign LINK.req_ready = (state_reg == tnl_pkg::NET_NORMAL);
    wire req_take = LINK.req_valid && LINK.req_ready;
    wire addr_hit = (LINK.req_route[0] == {9'h000, node_addr_reg});
    wire route_ok = (LINK.req_route[1] == tnl_pkg::SLAVE_ROUTE)
        && (LINK.req_route[2] == tnl_pkg::ROUTE_ZERO)
        && (LINK.req_route[3] == tnl_pkg::ROUTE_ZERO)
        && (LINK.req_route[4] == tnl_pkg::ROUTE_ZERO);
    wire [15:0] err_sel = (LINK.req_cmd != tnl_pkg::CMD_READ) ? tnl_pkg::ERR_CMD
        : (LINK.req_count != tnl_pkg::READ_COUNT) ? tnl_pkg::ERR_COUNT
        : (LINK.req_start != tnl_pkg::READ_START) ? tnl_pkg::ERR_START
        : !route_ok ? tnl_pkg::ERR_ROUTE
        : tnl_pkg::ERR_NONE;
    wire err_free = (err_sel == tnl_pkg::ERR_NONE);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rsp_valid_reg <= 1'b0;
            rsp_err_reg <= tnl_pkg::ERR_NONE;
            rsp_word0_reg <= 16'h0000;
            rsp_word1_reg <= 16'h0000;
        end else begin
            // a request for another node is silently dropped
            rsp_valid_reg <= req_take && addr_hit;
            if (req_take && addr_hit) begin
                rsp_err_reg <= err_sel;
                rsp_word0_reg <= err_free ? WEIGHT_WORD : 16'h0000;
                rsp_word1_reg <= err_free ? STATUS_WORD : 16'h0000;
            end
        end
    end

    assign LINK.rsp_valid = rsp_valid_reg;
    assign LINK.rsp_err = rsp_err_reg;
    assign LINK.rsp_word0 = rsp_word0_reg;
    assign LINK.rsp_word1 = rsp_word1_reg;
    assign LED = led_reg;
    assign NODE_ADDR = node_addr_reg;
    assign NET_STATE = state_reg;

endmodule : tnl_device_end

`default_nettype wire

// >>> pkg/tnl_pkg.sv
package tnl_pkg;

    // ----------------------------------------
    // clock and tick
    // ----------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    // cycles of CLK per millisecond tick
    localparam int MS_CYC = CLK_HZ / MS_PER_S;

    // ----------------------------------------
    // led timing, durations in milliseconds, flash counts in flashes
    // ----------------------------------------
    localparam logic [15:0] FLASH_ON_MS = 16'h0028; // 40 ms lit per flash
    localparam logic [15:0] SLOT_MS = 16'h00A0; // 160 ms
    localparam logic [15:0] OFFLINE_PERIOD_MS = 16'h03E8; // 1 s
    localparam logic [15:0] MONITOR_MS = 16'h1388; // 5 s
    localparam logic [15:0] DUP_QUIET_MS = 16'h1388; // 5 s
    localparam logic [15:0] IDLE_DARK_MS = 16'h07D0; // 2 s
    localparam logic [15:0] SOLO_DARK_MS = 16'h06A4; // 1.7 s
    localparam logic [15:0] DUP_DARK_MS = 16'h0578; // 1.4 s
    localparam logic [15:0] TOKEN_LOSS_MS = 16'h03E8; // 1 s
    localparam logic [15:0] TIMER_MAX = 16'hFFFF;
    localparam logic [2:0] ONE_FLASH = 3'h1;
    localparam logic [2:0] IDLE_FLASHES = 3'h2;
    localparam logic [2:0] SOLO_FLASHES = 3'h3;
    localparam logic [2:0] DUP_FLASHES = 3'h4;

    // ----------------------------------------
    // host answer timeout
    // ----------------------------------------
    localparam int HOST_TIMEOUT_MS = 1000;
    localparam int HOST_TIMEOUT_CYC = MS_CYC * HOST_TIMEOUT_MS;

    // ----------------------------------------
    // read request fields
    // ----------------------------------------
    localparam int ROUTES = 5;
    localparam int WORD_W = 16;
    localparam logic [15:0] CMD_READ = 16'h0002;
    localparam logic [15:0] READ_COUNT = 16'h0002;
    localparam logic [15:0] READ_START = 16'h0001;
    localparam logic [15:0] SLAVE_ROUTE = 16'h0001;
    localparam logic [15:0] ROUTE_ZERO = 16'h0000;
    localparam logic [6:0] ADDR_OFFSET = 7'h01;

    // ----------------------------------------
    // answer error codes
    // ----------------------------------------
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_CMD = 16'h0001;
    localparam logic [15:0] ERR_COUNT = 16'h0002;
    localparam logic [15:0] ERR_START = 16'h0003;
    localparam logic [15:0] ERR_ROUTE = 16'h0004;
    localparam logic [15:0] ERR_TIMEOUT = 16'h0005;

    typedef enum logic [2:0] {NET_OFFLINE, NET_NORMAL, NET_IDLE, NET_SOLO, NET_DUP} tnl_net_e;
    typedef enum logic [1:0] {HOST_IDLE, HOST_REQ, HOST_WAIT} tnl_host_e;

endpackage : tnl_pkg

// >>> pkg/tnl_link_if.sv
`timescale 1ns/10ps
`default_nettype none

interface tnl_link_if;
    logic req_valid;
    logic req_ready;
    logic [15:0] req_cmd;
    logic [15:0] req_count;
    logic [15:0] req_start;
    logic [4:0][15:0] req_route;
    logic rsp_valid;
    logic [15:0] rsp_err;
    logic [15:0] rsp_word0;
    logic [15:0] rsp_word1;

    modport dev (
        input req_valid,
        output req_ready,
        input req_cmd,
        input req_count,
        input req_start,
        input req_route,
        output rsp_valid,
        output rsp_err,
        output rsp_word0,
        output rsp_word1
    );

    modport host (
        output req_valid,
        input req_ready,
        output req_cmd,
        output req_count,
        output req_start,
        output req_route,
        input rsp_valid,
        input rsp_err,
        input rsp_word0,
        input rsp_word1
    );
endinterface : tnl_link_if

`default_nettype wire

// >>> src/tnl_host_end.sv
`timescale 1ns/10ps
`default_nettype none

module tnl_host_end #(
    parameter int TIMEOUT_CYC = tnl_pkg::HOST_TIMEOUT_CYC
) (
    input wire logic CLK, // system clock
    input wire logic RST, // async reset, high
    tnl_link_if.host LINK, // request link to terminal
    input wire logic START, // pulse: fetch one scale
    input wire logic [6:0] TARGET, // terminal node address
    output logic BUSY, // transfer in progress
    output logic DONE, // pulse: transfer over
    output logic [15:0] ERR, // answer or timeout code
    output logic [15:0] WEIGHT, // integer weight read
    output logic [15:0] STATUS // status word read
);

    localparam logic [23:0] WAIT_LAST = 24'(TIMEOUT_CYC - 1);

    tnl_pkg::tnl_host_e state_reg;
    logic [15:0] route0_reg;
    logic [23:0] wait_reg;
    logic done_reg;
    logic [15:0] err_reg;
    logic [15:0] weight_reg;
    logic [15:0] status_reg;

    // ----------------------------------------
    // request fields
    // ----------------------------------------
    assign LINK.req_valid = (state_reg == tnl_pkg::HOST_REQ);
    assign LINK.req_cmd = tnl_pkg::CMD_READ;
    assign LINK.req_count = tnl_pkg::READ_COUNT;
    assign LINK.req_start = tnl_pkg::READ_START;
    assign LINK.req_route[0] = route0_reg;
    assign LINK.req_route[1] = tnl_pkg::SLAVE_ROUTE;
    assign LINK.req_route[2] = tnl_pkg::ROUTE_ZERO;
    assign LINK.req_route[3] = tnl_pkg::ROUTE_ZERO;
    assign LINK.req_route[4] = tnl_pkg::ROUTE_ZERO;

    wire req_take = LINK.req_valid && LINK.req_ready;
    wire timed_out = (wait_reg == WAIT_LAST);
    // the wait covers both the handshake and the answer
    wire give_up = (state_reg != tnl_pkg::HOST_IDLE) && timed_out && !LINK.rsp_valid;
    wire got_rsp = (state_reg == tnl_pkg::HOST_WAIT) && LINK.rsp_valid;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg <= tnl_pkg::HOST_IDLE;
            route0_reg <= 16'h0000;
            wait_reg <= 24'h000000;
        end else begin
            unique case (state_reg)
                tnl_pkg::HOST_IDLE: begin
                    wait_reg <= 24'h000000;
                    if (START) begin
                        route0_reg <= {9'h000, TARGET};
                        state_reg <= tnl_pkg::HOST_REQ;
                    end
                end
                tnl_pkg::HOST_REQ: begin
                    wait_reg <= wait_reg + 24'h000001;
                    if (give_up) begin
                        state_reg <= tnl_pkg::HOST_IDLE;
                    end else if (req_take) begin
                        state_reg <= tnl_pkg::HOST_WAIT;
                    end
                end
                tnl_pkg::HOST_WAIT: begin
                    wait_reg <= wait_reg + 24'h000001;
                    if (got_rsp || give_up) begin
                        state_reg <= tnl_pkg::HOST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            done_reg <= 1'b0;
            err_reg <= tnl_pkg::ERR_NONE;
            weight_reg <= 16'h0000;
            status_reg <= 16'h0000;
        end else begin
            done_reg <= got_rsp || give_up;
            if (got_rsp) begin
                err_reg <= LINK.rsp_err;
                weight_reg <= LINK.rsp_word0;
                status_reg <= LINK.rsp_word1;
            end else if (give_up) begin
                err_reg <= tnl_pkg::ERR_TIMEOUT;
            end
        end
    end

    assign BUSY = (state_reg != tnl_pkg::HOST_IDLE);
    assign DONE = done_reg;
    assign ERR = err_reg;
    assign WEIGHT = weight_reg;
    assign STATUS = status_reg;

endmodule : tnl_host_end

`default_nettype wire

// >>> test/tnl_link_chk.sv
`timescale 1ns/10ps
`default_nettype none

module tnl_link_chk (
    input wire logic CLK, // system clock
    input wire logic RST, // async reset, high
    input wire logic req_valid, // request offered
    input wire logic req_ready, // terminal accepts
    input wire logic [15:0] req_cmd, // command word
    input wire logic [15:0] req_count, // register count
    input wire logic [15:0] req_start, // start register
    input wire logic [4:0][15:0] req_route, // routing path
    input wire logic rsp_valid, // answer strobe
    input wire logic [15:0] rsp_err, // answer code
    input wire logic [15:0] rsp_word0, // weight word
    input wire logic [15:0] rsp_word1 // status word
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    // ----------------------------------------
    // request fields
    // ----------------------------------------
    // read of two
    chk_read_cmd: assert property (req_valid |-> req_cmd == 16'h0002)
        else $error("request command is not a read");
    chk_read_count: assert property (req_valid |-> req_count == 16'h0002)
        else $error("request count is not two");
    chk_start_one: assert property (req_valid |-> req_start == 16'h0001)
        else $error("request start register wrong");
    chk_route_node: assert property (req_valid |-> req_route[0][15:7] == 9'h000
        && req_route[0][6:0] != 7'h00 && req_route[0][6:0] <= 7'h40)
        else $error("first route entry out of range");
    chk_slave_route: assert property (req_valid |-> req_route[1] == 16'h0001)
        else $error("data slave route entry wrong");
    chk_zero_routes: assert property (req_valid |-> req_route[2] == 16'h0000
        && req_route[3] == 16'h0000 && req_route[4] == 16'h0000)
        else $error("spare route entries not zero");
    chk_route_hold: assert property (req_valid && $past(req_valid) |-> $stable(req_route))
        else $error("route changed while request offered");

    // ----------------------------------------
    // answer timing
    // ----------------------------------------
    // at most one answer per accept
    chk_answer_cause: assert property (rsp_valid |-> $past(req_valid && req_ready))
        else $error("answer without an accepted request");
    chk_answer_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer strobe longer than one cycle");
    chk_valid_drop: assert property (req_valid && req_ready |=> !req_valid[*2])
        else $error("request still offered after accept");
    chk_err_words: assert property (rsp_valid && rsp_err != 16'h0000
        |-> rsp_word0 == 16'h0000 && rsp_word1 == 16'h0000)
        else $error("error answer carries data");
endmodule : tnl_link_chk

`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    localparam int MSC = 4;
    logic clk, rst, start, tok_on;
    logic [6:0] target, node;
    logic [5:0] sw;
    logic [3:0] ev;
    logic [8:0] tcnt = 9'h000;
    logic [15:0] wt, st, last_w, last_s;
    logic led, busy, done;
    logic [6:0] node_addr;
    tnl_pkg::tnl_net_e net_state;
    logic [15:0] err, weight, status;
    integer seed, n_mismatch, compares, k;
    // keepalive token every 512 cycles, well inside the loss watchdog
    wire logic token = ev[0] | (tok_on & (tcnt == 9'h000));

    tnl_link_if link ();
    tnl_device_end #(.MS_CYC(MSC)) tnl_device_end_inst (.CLK(clk), .RST(rst), .LINK(link),
        .ADDR_SW_ON(sw), .TOKEN_PASS(token), .OTHER_HEARD(ev[1]), .SOLO_CLAIM(ev[2]),
        .DUP_HEARD(ev[3]), .WEIGHT_WORD(wt), .STATUS_WORD(st), .LED(led),
        .NODE_ADDR(node_addr), .NET_STATE(net_state));
    tnl_host_end #(.TIMEOUT_CYC(200)) tnl_host_end_inst (.CLK(clk), .RST(rst), .LINK(link),
        .START(start), .TARGET(target), .BUSY(busy), .DONE(done), .ERR(err),
        .WEIGHT(weight), .STATUS(status));
    tnl_link_chk chk_inst (.CLK(clk), .RST(rst), .req_valid(link.req_valid),
        .req_ready(link.req_ready), .req_cmd(link.req_cmd), .req_count(link.req_count),
        .req_start(link.req_start), .req_route(link.req_route), .rsp_valid(link.rsp_valid),
        .rsp_err(link.rsp_err), .rsp_word0(link.rsp_word0), .rsp_word1(link.rsp_word1));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [6:0] node_of(input logic [5:0] s);
        node_of = {1'b0, ~s} + 7'h01;
    endfunction : node_of

    function automatic int period_ms(input int n, input logic [15:0] dark);
        period_ms = (n - 1) * int'(tnl_pkg::SLOT_MS) + int'(tnl_pkg::FLASH_ON_MS) + int'(dark);
    endfunction : period_ms

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task results;
        if (n_mismatch == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    // counts rising flashes over one pattern period; a lit led at entry counts too
    task flashes(input int n, input logic [15:0] dark);
        integer i, c;
        logic p;
        c = 0;
        p = 1'b0;
        for (i = 0; i < period_ms(n, dark) * MSC - 8; i = i + 1) begin
            @(negedge clk);
            if (led === 1'b1 && p !== 1'b1) begin
                c = c + 1;
            end
            p = led;
        end
        check(c, n);
    endtask : flashes

    task enter(input int b, input tnl_pkg::tnl_net_e s);
        @(negedge clk);
        ev[b] = 1'b1;
        @(negedge clk);
        ev = 4'h0;
        check(net_state, s);
        @(negedge clk);
        check(led, 1'b1);
    endtask : enter

    task fetch(input logic [6:0] tgt, input logic [15:0] e_err);
        integer i;
        @(negedge clk);
        start = 1'b1;
        target = tgt;
        @(negedge clk);
        start = 1'b0;
        check(busy, 1'b1);
        i = 0;
        while (done !== 1'b1 && i < 400) begin
            @(negedge clk);
            i = i + 1;
        end
        if (e_err == tnl_pkg::ERR_NONE) begin
            last_w = wt;
            last_s = st;
        end
        check(busy, 1'b0);
        check(err, e_err);
        check(weight, last_w);
        check(status, last_s);
    endtask : fetch

    // ----------------------------------------
    // clock, keepalive, watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(negedge clk) begin
        tcnt <= tcnt + 9'h001;
    end

    initial begin
        repeat (80000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        results;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = 27;
        n_mismatch = 0;
        compares = 0;
        rst = 1'b1;
        start = 1'b0;
        tok_on = 1'b0;
        ev = 4'h0;
        target = 7'h00;
        sw = 6'($random(seed));
        wt = 16'($random(seed));
        st = 16'($random(seed));
        last_w = 16'h0000;
        last_s = 16'h0000;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        tok_on = 1'b1;
        node = node_of(sw);
        @(negedge clk);
        check(node_addr, node);
        check(net_state, tnl_pkg::NET_OFFLINE);
        flashes(1, tnl_pkg::OFFLINE_PERIOD_MS - tnl_pkg::FLASH_ON_MS);
        repeat (3980 * MSC) @(negedge clk);
        check(net_state, tnl_pkg::NET_OFFLINE);
        k = 0;
        while (net_state !== tnl_pkg::NET_NORMAL && k < 200) begin
            @(negedge clk);
            k = k + 1;
        end
        check(net_state, tnl_pkg::NET_NORMAL);
        flashes(1, tnl_pkg::SLOT_MS - tnl_pkg::FLASH_ON_MS);
        // back-to-back reads with fresh random words
        for (k = 0; k < 3; k = k + 1) begin
            wt = 16'($random(seed));
            st = 16'($random(seed));
            fetch(node, tnl_pkg::ERR_NONE);
        end
        // wrong node: dropped, host times out, words kept
        fetch((node == 7'h01) ? 7'h02 : node - 7'h01, tnl_pkg::ERR_TIMEOUT);
        tok_on = 1'b0;
        enter(2, tnl_pkg::NET_SOLO);
        flashes(3, tnl_pkg::SOLO_DARK_MS);
        enter(1, tnl_pkg::NET_IDLE);
        flashes(2, tnl_pkg::IDLE_DARK_MS);
        enter(0, tnl_pkg::NET_NORMAL);
        enter(3, tnl_pkg::NET_DUP);
        flashes(4, tnl_pkg::DUP_DARK_MS);
        // a fresh duplicate packet restarts the quiet time
        @(negedge clk);
        ev[3] = 1'b1;
        @(negedge clk);
        ev = 4'h0;
        check(net_state, tnl_pkg::NET_DUP);
        repeat (4990 * MSC - 1) @(negedge clk);
        check(net_state, tnl_pkg::NET_DUP);
        repeat (20 * MSC) @(negedge clk);
        check(net_state, tnl_pkg::NET_OFFLINE);
        // switch corners: worked example, all ON, all OFF
        sw = 6'h26;
        @(negedge clk);
        check(node_addr, 7'h1A);
        sw = 6'h3F;
        @(negedge clk);
        check(node_addr, 7'h01);
        sw = 6'h00;
        @(negedge clk);
        check(node_addr, 7'h40);
        results;
    end
endmodule : tb_top

`default_nettype wire
